// ==== logic/isa_bridge_cycle_config_regs.sv ====
// Purpose: Byte-wide ISA bridge configuration registers and the bridge controls they steer.
// Assumes: All inputs synchronous to ref_clk; Avalon-MM master holds a request until waitrequest is low.
// Notes: Each register sits in the low byte of one aligned word; upper bits read as zero.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
`include "bridge_cfg_map.svh"

// Functional notes
// - Cycle control bit 7 enables fast-reset port; its writes can fire fast CPU reset.
// - Bit 6 low: error pin is IRQ13 input, ignore-error output held high.
// - Bits 5-4 pick refresh interval of 15, 30, 60 or 120 microseconds.
// - Bits 3-2 add zero to three wait states to 16-bit memory commands.
// - Bits 1-0 add zero to three wait states to 16-bit I/O commands.
// - Register 44h bit 7 lets a CPU soft reset also drive PCI reset.
// - Bit 6 picks positive or subtractive on-chip decode; DMA ports always subtractive.
// - Bit 4 turns IDE primary level interrupt into an edge; else passes through.
// - Bits 3-0 route IDE primary interrupt to an ISA IRQ in native mode.
// - Reserved route codes 1010, 1100 and 1110 disable the interrupt.
// - Register 45h bit 7 enables PCI interrupt polling mode.
// - Bit 6 extends ROM select from ports 60h, 64h to 62h, 66h too.
// - Bit 3 enables the delayed-transaction timeout counter.
// - Bit 1 enables distributed DMA.
// - Bit 0 enables bus parity checking.
// - ISA cycle control register resets to zero.
// - Index 46h is reserved with no control behind it.
module isa_bridge_cycle_config_regs #(
  parameter logic [15:0] refresh_base_cycles = 16'(`REFRESH_BASE_CYCLES)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fast_reset_port_wr,
  input wire logic [7:0] fast_reset_port_wdata,
  output logic fast_cpu_reset,
  output logic addr_line_gate,
  input wire logic coproc_error_pin,
  input wire logic ignne_request,
  output logic external_coproc_irq_in,
  output logic coproc_error_report,
  output logic ignore_numeric_error_out,
  output logic refresh_request,
  input wire logic isa16_cmd_start,
  input wire logic isa16_cmd_is_mem,
  output logic isa16_cmd_hold,
  input wire logic cpu_soft_reset,
  output logic pci_bus_reset_out_n,
  input wire logic io_cycle_valid,
  input wire logic io_cycle_is_dma,
  input wire logic [15:0] io_cycle_port,
  output logic onchip_decode_subtractive,
  output logic rom_chip_select,
  input wire logic ide_native_mode,
  input wire logic ide_primary_irq,
  output logic [15:0] isa_irq_from_ide,
  output logic pci_irq_polling_en,
  output logic dt_timeout_en,
  output logic distributed_dma_en,
  output logic parity_check_en,
  output logic [7:0] boot_rom_select
);

  // ---------------------------------------------------------------
  // Register bus slave
  // ---------------------------------------------------------------

  bridge_cfg_pkg::bus_state_e state_r, state_nxt;
  logic waitrequest_r, waitrequest_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  bridge_cfg_pkg::isa_cycle_s cycle_r, cycle_nxt;
  bridge_cfg_pkg::reset_decode_s rdec_r, rdec_nxt;
  logic [7:0] misc_r, misc_nxt;
  logic [7:0] rom_r, rom_nxt;
  logic [7:0] index;
  logic aligned;
  logic commit_wr;
  logic [7:0] wbyte;

  // Index decode: only word-aligned byte addresses hit a register.
  assign index = avs_address[9:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  assign commit_wr = (state_r == bridge_cfg_pkg::BUS_ACK) && avs_write && aligned && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // Handshake: waitrequest drops for one cycle after a request is seen.
  always_comb
  begin
    state_nxt = bridge_cfg_pkg::BUS_IDLE;
    waitrequest_nxt = 1'b1;
    readdata_nxt = readdata_r;
    unique case (state_r)
      bridge_cfg_pkg::BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          state_nxt = bridge_cfg_pkg::BUS_ACK;
          waitrequest_nxt = 1'b0;
          readdata_nxt = 32'h0000_0000;
          if (avs_read && aligned)
          begin
            unique case (index)
              `IDX_ISA_CYCLE_CONTROL: readdata_nxt[7:0] = cycle_r;
              `IDX_RESET_DECODE_IDE: readdata_nxt[7:0] = rdec_r;
              `IDX_MISC_FEATURE: readdata_nxt[7:0] = misc_r;
              `IDX_BOOT_ROM_SELECT: readdata_nxt[7:0] = rom_r;
              default: readdata_nxt = 32'h0000_0000;
            endcase
          end
        end
      end
      bridge_cfg_pkg::BUS_ACK:
      begin
        state_nxt = bridge_cfg_pkg::BUS_IDLE;
        waitrequest_nxt = 1'b1;
      end
    endcase
  end

  // Handshake registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= bridge_cfg_pkg::BUS_IDLE;
      waitrequest_r <= 1'b1;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      waitrequest_r <= waitrequest_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // Register writes take effect at the edge where waitrequest is low.
  always_comb
  begin
    cycle_nxt = cycle_r;
    rdec_nxt = rdec_r;
    misc_nxt = misc_r;
    rom_nxt = rom_r;
    if (commit_wr)
    begin
      unique case (index)
        `IDX_ISA_CYCLE_CONTROL: cycle_nxt = wbyte;
        `IDX_RESET_DECODE_IDE: rdec_nxt = wbyte;
        `IDX_MISC_FEATURE: misc_nxt = wbyte & `MISC_WRITE_MASK;
        `IDX_BOOT_ROM_SELECT: rom_nxt = wbyte;
        default: rom_nxt = rom_r;
      endcase
    end
  end

  // Configuration registers, all zero after reset.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cycle_r <= `RST_ISA_CYCLE_CONTROL;
      rdec_r <= `RST_RESET_DECODE_IDE;
      misc_r <= `RST_MISC_FEATURE;
      rom_r <= `RST_BOOT_ROM_SELECT;
    end
    else
    begin
      cycle_r <= cycle_nxt;
      rdec_r <= rdec_nxt;
      misc_r <= misc_nxt;
      rom_r <= rom_nxt;
    end
  end

  assign avs_waitrequest = waitrequest_r;
  assign avs_readdata = readdata_r;

  // ---------------------------------------------------------------
  // Fast reset port and coprocessor pin
  // ---------------------------------------------------------------

  logic fast_rst_r, fast_rst_nxt;
  logic gate_r, gate_nxt;
  logic port_bit0_r, port_bit0_nxt;
  logic irq13_r, irq13_nxt;
  logic ferr_r, ferr_nxt;
  logic ignne_r, ignne_nxt;

  // A 0-to-1 write of port bit 0 fires a one-cycle fast CPU reset.
  always_comb
  begin
    fast_rst_nxt = 1'b0;
    gate_nxt = gate_r;
    port_bit0_nxt = port_bit0_r;
    if (fast_reset_port_wr && cycle_r.fast_reset_en)
    begin
      gate_nxt = fast_reset_port_wdata[1];
      port_bit0_nxt = fast_reset_port_wdata[0];
      fast_rst_nxt = fast_reset_port_wdata[0] && !port_bit0_r;
    end
  end

  // Pin role follows the coprocessor enable bit.
  always_comb
  begin
    irq13_nxt = !cycle_r.coproc_report_en && coproc_error_pin;
    ferr_nxt = cycle_r.coproc_report_en && coproc_error_pin;
    ignne_nxt = cycle_r.coproc_report_en ? ignne_request : 1'b1;
  end

  // Port and coprocessor registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fast_rst_r <= 1'b0;
      gate_r <= 1'b0;
      port_bit0_r <= 1'b0;
      irq13_r <= 1'b0;
      ferr_r <= 1'b0;
      ignne_r <= 1'b1;
    end
    else
    begin
      fast_rst_r <= fast_rst_nxt;
      gate_r <= gate_nxt;
      port_bit0_r <= port_bit0_nxt;
      irq13_r <= irq13_nxt;
      ferr_r <= ferr_nxt;
      ignne_r <= ignne_nxt;
    end
  end

  assign fast_cpu_reset = fast_rst_r;
  assign addr_line_gate = gate_r;
  assign external_coproc_irq_in = irq13_r;
  assign coproc_error_report = ferr_r;
  assign ignore_numeric_error_out = ignne_r;

  // ---------------------------------------------------------------
  // Refresh timer and ISA command stretcher
  // ---------------------------------------------------------------

  logic [18:0] refresh_cnt_r, refresh_cnt_nxt;
  logic refresh_r, refresh_nxt;
  logic [18:0] refresh_period;
  logic [1:0] hold_cnt_r, hold_cnt_nxt;
  logic hold_r, hold_nxt;
  bridge_cfg_pkg::isa_cmd_s cmd;

  // Period doubles with each step of the select code.
  assign refresh_period = 19'({3'h0, refresh_base_cycles} << cycle_r.refresh_sel);
  assign cmd = '{start: isa16_cmd_start, is_mem: isa16_cmd_is_mem};

  // Refresh request pulses once per period.
  always_comb
  begin
    refresh_nxt = 1'b0;
    refresh_cnt_nxt = refresh_cnt_r + 19'h1;
    if (refresh_cnt_r >= refresh_period - 19'h1)
    begin
      refresh_cnt_nxt = 19'h0;
      refresh_nxt = 1'b1;
    end
  end

  // Hold stays high for the programmed number of extra waits.
  always_comb
  begin
    hold_cnt_nxt = hold_cnt_r;
    hold_nxt = 1'b0;
    if (cmd.start)
    begin
      hold_cnt_nxt = cmd.is_mem ? cycle_r.mem_wait : cycle_r.io_wait;
      hold_nxt = (hold_cnt_nxt != 2'h0);
    end
    else if (hold_cnt_r != 2'h0)
    begin
      hold_cnt_nxt = hold_cnt_r - 2'h1;
      hold_nxt = (hold_cnt_nxt != 2'h0);
    end
  end

  // Refresh and stretcher registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refresh_cnt_r <= 19'h0;
      refresh_r <= 1'b0;
      hold_cnt_r <= 2'h0;
      hold_r <= 1'b0;
    end
    else
    begin
      refresh_cnt_r <= refresh_cnt_nxt;
      refresh_r <= refresh_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign refresh_request = refresh_r;
  assign isa16_cmd_hold = hold_r;

  // ---------------------------------------------------------------
  // PCI reset, decode and ROM select
  // ---------------------------------------------------------------

  logic [7:0] pcirst_cnt_r, pcirst_cnt_nxt;
  logic pcirst_n_r, pcirst_n_nxt;
  logic subtr_r, subtr_nxt;
  logic romcs_r, romcs_nxt;

  // Soft reset starts a PCI reset pulse only when enabled.
  always_comb
  begin
    pcirst_cnt_nxt = pcirst_cnt_r;
    if (cpu_soft_reset && rdec_r.soft_reset_pci)
      pcirst_cnt_nxt = 8'(`PCIRST_HOLD_CYCLES);
    else if (pcirst_cnt_r != 8'h0)
      pcirst_cnt_nxt = pcirst_cnt_r - 8'h1;
    pcirst_n_nxt = (pcirst_cnt_nxt == 8'h0);
  end

  // Decode style and keyboard-port ROM select.
  always_comb
  begin
    subtr_nxt = rdec_r.subtractive || io_cycle_is_dma;
    romcs_nxt = io_cycle_valid &&
                ((io_cycle_port == `KBD_DATA_PORT) || (io_cycle_port == `KBD_CMD_PORT) ||
                 (misc_r[`MISC_ROM_6266_BIT] &&
                  ((io_cycle_port == `EC_DATA_PORT) || (io_cycle_port == `EC_CMD_PORT))));
  end

  // Reset, decode and ROM select registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pcirst_cnt_r <= 8'h0;
      pcirst_n_r <= 1'b1;
      subtr_r <= 1'b0;
      romcs_r <= 1'b0;
    end
    else
    begin
      pcirst_cnt_r <= pcirst_cnt_nxt;
      pcirst_n_r <= pcirst_n_nxt;
      subtr_r <= subtr_nxt;
      romcs_r <= romcs_nxt;
    end
  end

  assign pci_bus_reset_out_n = pcirst_n_r;
  assign onchip_decode_subtractive = subtr_r;
  assign rom_chip_select = romcs_r;

  // ---------------------------------------------------------------
  // IDE primary interrupt routing
  // ---------------------------------------------------------------

  logic ide_prev_r, ide_prev_nxt;
  logic [15:0] irq_r, irq_nxt;
  logic ide_src;

  // Maps a route code to a one-hot ISA IRQ vector.
  function automatic logic [15:0] route_onehot(input logic [3:0] code);
    logic [15:0] v;
    v = 16'h0000;
    unique case (code)
      4'h1: v[9] = 1'b1;
      4'h2: v[3] = 1'b1;
      4'h3: v[10] = 1'b1;
      4'h4: v[4] = 1'b1;
      4'h5: v[5] = 1'b1;
      4'h6: v[7] = 1'b1;
      4'h7: v[6] = 1'b1;
      4'h8: v[1] = 1'b1;
      4'h9: v[11] = 1'b1;
      4'hb: v[12] = 1'b1;
      4'hd: v[14] = 1'b1;
      4'hf: v[15] = 1'b1;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Edge mode passes only the rising edge of the level interrupt.
  assign ide_src = rdec_r.level_to_edge ? (ide_primary_irq && !ide_prev_r) : ide_primary_irq;

  // Routed interrupt, only in native mode.
  always_comb
  begin
    ide_prev_nxt = ide_primary_irq;
    irq_nxt = (ide_native_mode && ide_src) ? route_onehot(rdec_r.irq_route) : 16'h0000;
  end

  // Interrupt registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ide_prev_r <= 1'b0;
      irq_r <= 16'h0000;
    end
    else
    begin
      ide_prev_r <= ide_prev_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign isa_irq_from_ide = irq_r;

  // ---------------------------------------------------------------
  // Feature enables
  // ---------------------------------------------------------------

  // Straight from the register flip-flops.
  assign pci_irq_polling_en = misc_r[`MISC_POLL_BIT];
  assign dt_timeout_en = misc_r[`MISC_DT_TIMEOUT_BIT];
  assign distributed_dma_en = misc_r[`MISC_DDMA_BIT];
  assign parity_check_en = misc_r[`MISC_PARITY_BIT];
  assign boot_rom_select = rom_r;

endmodule

// ==== pkg/bridge_cfg_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the ISA bridge configuration registers.
// Assumes: 250 MHz ref_clk.
// Notes: Byte address of a register is four times its index.
`ifndef BRIDGE_CFG_MAP_SVH
`define BRIDGE_CFG_MAP_SVH

`define IDX_ISA_CYCLE_CONTROL 8'h43
`define IDX_RESET_DECODE_IDE 8'h44
`define IDX_MISC_FEATURE 8'h45
`define IDX_RESERVED 8'h46
`define IDX_BOOT_ROM_SELECT 8'h47

`define RST_ISA_CYCLE_CONTROL 8'h00
`define RST_RESET_DECODE_IDE 8'h00
`define RST_MISC_FEATURE 8'h00
`define RST_BOOT_ROM_SELECT 8'h00

`define MISC_WRITE_MASK 8'hcb
`define RDEC_SOFT_RESET_BIT 7
`define RDEC_SUBTRACTIVE_BIT 6
`define RDEC_EDGE_BIT 4
`define MISC_POLL_BIT 7
`define MISC_ROM_6266_BIT 6
`define MISC_DT_TIMEOUT_BIT 3
`define MISC_DDMA_BIT 1
`define MISC_PARITY_BIT 0

`define CLK_MHZ 250
`define REFRESH_BASE_NS 15000
`define REFRESH_BASE_CYCLES ((`REFRESH_BASE_NS * `CLK_MHZ) / 1000)
`define PCIRST_HOLD_NS 64
`define PCIRST_HOLD_CYCLES ((`PCIRST_HOLD_NS * `CLK_MHZ + 999) / 1000)

`define KBD_DATA_PORT 16'h0060
`define KBD_CMD_PORT 16'h0064
`define EC_DATA_PORT 16'h0062
`define EC_CMD_PORT 16'h0066

`endif

// ==== pkg/bridge_cfg_pkg.sv ====
// Purpose: Types shared by the ISA bridge configuration register block.
// Assumes: Nothing beyond the map header.
// Notes: Field layouts follow the register bit order, msb first.
package bridge_cfg_pkg;

  // Field layout of the ISA cycle control register.
  typedef struct packed {
    logic fast_reset_en;
    logic coproc_report_en;
    logic [1:0] refresh_sel;
    logic [1:0] mem_wait;
    logic [1:0] io_wait;
  } isa_cycle_s;

  // Field layout of the reset, decode and IDE interrupt register.
  typedef struct packed {
    logic soft_reset_pci;
    logic subtractive;
    logic reserved_zero;
    logic level_to_edge;
    logic [3:0] irq_route;
  } reset_decode_s;

  // One request on the ISA command stretcher.
  typedef struct packed {
    logic start;
    logic is_mem;
  } isa_cmd_s;

  // Slave handshake states.
  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage

// ==== verification/bridge_cfg_sva.sv ====
// Purpose: Port-level assertions for the ISA bridge configuration block.
// Assumes: Refresh base handed on from the design parameter.
// Notes: Attached by the bind at the foot of this file.
`timescale 1ns/10ps
module bridge_cfg_sva #(
  parameter logic [15:0] refresh_base_cycles = 16'h0008
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic fast_reset_port_wr,
  input wire logic [7:0] fast_reset_port_wdata,
  input wire logic fast_cpu_reset,
  input wire logic external_coproc_irq_in,
  input wire logic coproc_error_report,
  input wire logic ignore_numeric_error_out,
  input wire logic refresh_request,
  input wire logic isa16_cmd_start,
  input wire logic isa16_cmd_hold,
  input wire logic cpu_soft_reset,
  input wire logic pci_bus_reset_out_n,
  input wire logic io_cycle_valid,
  input wire logic io_cycle_is_dma,
  input wire logic [15:0] io_cycle_port,
  input wire logic onchip_decode_subtractive,
  input wire logic rom_chip_select,
  input wire logic [15:0] isa_irq_from_ide
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [19:0] gap_r;
  logic [19:0] gap_nxt;
  // Counts cycles since the last refresh pulse.
  always_comb gap_nxt = refresh_request ? 20'h0 : gap_r + 20'h1;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n) gap_r <= 20'h0;
    else gap_r <= gap_nxt;
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_coproc_modes: assert property (external_coproc_irq_in |-> ignore_numeric_error_out && !coproc_error_report)
    else $error("coprocessor pin modes mixed");
  chk_fast_cause: assert property (fast_cpu_reset |-> $past(fast_reset_port_wr) && $past(fast_reset_port_wdata[0]) ##1 !fast_cpu_reset)
    else $error("fast reset pulse without port write");
  chk_refresh_min: assert property (refresh_request |-> gap_r + 20'h1 >= 20'(refresh_base_cycles))
    else $error("refresh pulses too close");
  chk_refresh_max: assert property (gap_r < 20'(refresh_base_cycles) * 20'h8)
    else $error("refresh pulse overdue");
  chk_hold_cause: assert property ($rose(isa16_cmd_hold) |-> $past(isa16_cmd_start))
    else $error("command hold without start");
  chk_hold_bound: assert property (isa16_cmd_hold [*3] |=> !isa16_cmd_hold)
    else $error("command hold above three waits");
  chk_pcirst_len: assert property ($fell(pci_bus_reset_out_n) |-> $past(cpu_soft_reset) ##15 !pci_bus_reset_out_n ##1 pci_bus_reset_out_n)
    else $error("bus reset pulse wrong");
  chk_dma_subtr: assert property (io_cycle_valid && io_cycle_is_dma |=> onchip_decode_subtractive)
    else $error("dma port not subtractive");
  chk_rom_ports: assert property (rom_chip_select |-> $past(io_cycle_valid) && ($past(io_cycle_port) inside {16'h0060, 16'h0064, 16'h0062, 16'h0066}))
    else $error("rom select on wrong port");
  chk_irq_route: assert property ($onehot0(isa_irq_from_ide) && (isa_irq_from_ide & 16'h2105) == 16'h0)
    else $error("ide irq vector illegal");
endmodule
bind isa_bridge_cycle_config_regs bridge_cfg_sva #(.refresh_base_cycles(refresh_base_cycles)) chk_u (.*);

// ==== verification/isa_bridge_cycle_config_regs_tb.sv ====
// Purpose: Self-checking bench for the ISA bridge configuration block.
// Assumes: Refresh base shortened to 8 cycles.
// Notes: A register sits at four times its index.
`timescale 1ns/10ps
module isa_bridge_cycle_config_regs_tb;
  logic ref_clk, rst_n, avs_read, avs_write, fast_reset_port_wr, coproc_error_pin, ignne_request;
  logic isa16_cmd_start, isa16_cmd_is_mem, cpu_soft_reset, io_cycle_valid, io_cycle_is_dma;
  logic ide_native_mode, ide_primary_irq, avs_waitrequest, fast_cpu_reset, addr_line_gate;
  logic external_coproc_irq_in, coproc_error_report, ignore_numeric_error_out, refresh_request;
  logic isa16_cmd_hold, pci_bus_reset_out_n, onchip_decode_subtractive, rom_chip_select;
  logic pci_irq_polling_en, dt_timeout_en, distributed_dma_en, parity_check_en;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [7:0] fast_reset_port_wdata, boot_rom_select;
  logic [15:0] io_cycle_port, isa_irq_from_ide;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int h;
  int irq_of[16] = '{0, 9, 3, 10, 4, 5, 7, 6, 1, 11, 0, 12, 0, 14, 0, 15};
  isa_bridge_cycle_config_regs #(.refresh_base_cycles(16'h0008)) dut_u (.*);
  // Clock and hang limit.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One Avalon transfer, held until waitrequest is sampled low.
  // Only the bench's cycle ceiling ends a wait that never gets its answer.
  task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do
      @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    bus(1'b1, {i, 2'b00}, d);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    bus(1'b0, {i, 2'b00}, 8'h00);
    ck(q, {24'h0, e});
  endtask
  task automatic cnt(ref logic s, input int c, output int n);
    n = 0;
    repeat (c)
    begin
      @(posedge ref_clk);
      // An unknown level is a mismatch rather than a silent zero.
      if (s !== 1'b0 && s !== 1'b1) ck({31'h0, s}, 32'h0);
      n += int'(s);
    end
  endtask
  task automatic cmd(input logic m, output int n);
    @(posedge ref_clk);
    isa16_cmd_start <= 1'b1;
    isa16_cmd_is_mem <= m;
    @(posedge ref_clk);
    isa16_cmd_start <= 1'b0;
    cnt(isa16_cmd_hold, 6, n);
  endtask
  // Skips one refresh interval, then measures the next.
  task automatic gap(output int n);
    repeat (2)
    begin
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (refresh_request !== 1'b1);
    end
  endtask
  task automatic port(input logic [7:0] d);
    @(posedge ref_clk);
    fast_reset_port_wr <= 1'b1;
    fast_reset_port_wdata <= d;
    @(posedge ref_clk);
    fast_reset_port_wr <= 1'b0;
  endtask
  task automatic io(input logic dma, input logic [15:0] p, input logic [1:0] e);
    @(posedge ref_clk);
    io_cycle_valid <= 1'b1;
    io_cycle_is_dma <= dma;
    io_cycle_port <= p;
    @(posedge ref_clk);
    io_cycle_valid <= 1'b0;
    @(posedge ref_clk);
    ck({onchip_decode_subtractive, rom_chip_select}, e);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {ref_clk, rst_n, avs_read, avs_write, fast_reset_port_wr, coproc_error_pin, ignne_request} = '0;
    {isa16_cmd_start, isa16_cmd_is_mem, cpu_soft_reset, io_cycle_valid, io_cycle_is_dma} = '0;
    {ide_native_mode, ide_primary_irq, avs_address, avs_writedata, fast_reset_port_wdata, io_cycle_port} = '0;
    avs_byteenable = 4'hf;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (irq_of[j]) if (j < 5 && j != 3) rd(8'(8'h43 + j), 8'h00);
    ck({ignore_numeric_error_out, pci_bus_reset_out_n}, 2'b11);
    $display("reset test done");
    wr(8'h43, 8'ha5);
    rd(8'h43, 8'ha5);
    wr(8'h44, 8'hdf);
    rd(8'h44, 8'hdf);
    wr(8'h45, 8'hff);
    rd(8'h45, 8'hcb);
    ck({pci_irq_polling_en, dt_timeout_en, distributed_dma_en, parity_check_en}, 4'hf);
    wr(8'h47, 8'h5a);
    avs_byteenable <= 4'he;
    wr(8'h47, 8'hff);
    avs_byteenable <= 4'hf;
    rd(8'h47, 8'h5a);
    ck(boot_rom_select, 8'h5a);
    wr(8'h45, 8'h00);
    wr(8'h46, 8'hff);
    rd(8'h46, 8'h00);
    rd(8'h50, 8'h00);
    bus(1'b0, 10'h10d, 8'h00);
    ck(q, 32'h0);
    ck({pci_irq_polling_en, dt_timeout_en, distributed_dma_en, parity_check_en}, 4'h0);
    $display("access test done");
    coproc_error_pin <= 1'b1;
    wr(8'h43, 8'h00);
    cnt(refresh_request, 2, h);
    ck({external_coproc_irq_in, coproc_error_report, ignore_numeric_error_out}, 3'b101);
    wr(8'h43, 8'h40);
    cnt(refresh_request, 2, h);
    ck({external_coproc_irq_in, coproc_error_report, ignore_numeric_error_out}, 3'b010);
    ignne_request <= 1'b1;
    cnt(refresh_request, 2, h);
    ck(ignore_numeric_error_out, 1'b1);
    $display("coprocessor test done");
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h43, 8'(3 * m + 3));
      cmd(1'b1, h);
      ck(h, m);
      cmd(1'b0, h);
      ck(h, 3 - m);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h43, 8'(16 * c));
      gap(h);
      ck(h, 8 << c);
    end
    $display("timing test done");
    wr(8'h43, 8'h00);
    port(8'h00);
    port(8'h03);
    cnt(fast_cpu_reset, 3, h);
    ck({h[1:0], addr_line_gate}, 3'b000);
    wr(8'h43, 8'h80);
    port(8'h00);
    port(8'h03);
    cnt(fast_cpu_reset, 3, h);
    ck({h[1:0], addr_line_gate}, 3'b011);
    for (int b = 0; b < 2; b++)
    begin
      wr(8'h44, 8'(b * 128));
      @(posedge ref_clk);
      cpu_soft_reset <= 1'b1;
      @(posedge ref_clk);
      cpu_soft_reset <= 1'b0;
      cnt(pci_bus_reset_out_n, 20, h);
      ck(20 - h, 16 * b);
    end
    $display("reset output test done");
    wr(8'h44, 8'h00);
    io(1'b0, 16'h0060, 2'b01);
    io(1'b1, 16'h0062, 2'b10);
    wr(8'h45, 8'h40);
    io(1'b0, 16'h0066, 2'b01);
    wr(8'h44, 8'h40);
    io(1'b0, 16'h0064, 2'b11);
    $display("decode test done");
    ide_native_mode <= 1'b1;
    ide_primary_irq <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      wr(8'h44, 8'(k));
      cnt(refresh_request, 3, h);
      ck(isa_irq_from_ide, irq_of[k] == 0 ? 32'h0 : 32'h1 << irq_of[k]);
    end
    ide_primary_irq <= 1'b0;
    wr(8'h44, 8'h11);
    cnt(refresh_request, 2, h);
    ide_primary_irq <= 1'b1;
    h = 0;
    repeat (6)
    begin
      @(posedge ref_clk);
      h += int'(isa_irq_from_ide[9]);
    end
    ck(h, 1);
    $display("ide test done");
    wrap_up();
  end
endmodule
